// ### ltcap_top.sv
// Lite timebase and capture timer with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "ltcap_defines.svh"

// Operation
// - Hidden counter 1 counts from zero at tick
// - Counter 1 wraps F9h to 00h, overflow
// - Period select doubles counter 1 overflow interval
// - Period is 8000 or 16000 oscillator periods
// - Counter 1 overflow sets flag, enabled irq
// - Reading first status register clears flag 1
// - Readable counter 2 starts at reload value
// - Counter 2 past FFh reloads, overflows
// - New reload value applied at next overflow
// - Counter 2 overflow sets flag, enabled irq
// - Reading second status register clears flag 2
// - Pin edge captures counter 1, sets flag
// - Capture raises irq when enabled
// - Reading capture register clears capture flag
// - Capture edges ignored while flag set
// - Capture register read-only, last accepted value
// - Halt stops counters; other modes no effect
// - Separate vectors, gated by enable and mask
module ltcap_top #(
    parameter int ADDR_W = 8,
    parameter int TICK_CYC = `LTCAP_TICK_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // System state
    input wire logic halt_mode,
    input wire logic cpu_irq_mask,
    // Capture pin
    input wire logic capture_input_pin,
    // Interrupt requests
    output logic irq_timebase1,
    output logic irq_timebase2,
    output logic irq_capture,
    output logic irq
);
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_addr_chk
        $error("ltcap_top: ADDR_W must lie between 8 and 32");
    end

    // Address decode, shared by the read mux and the register writes
    function automatic ltcap_pkg::ltcap_sel_type sel_of(
        input logic [ADDR_W-1:0] a
    );
        ltcap_pkg::ltcap_sel_type s;
        s = ltcap_pkg::LTCAP_SEL_NONE;
        if ((a >> 8) == '0 && a[1:0] == 2'h0) begin
            case (a[7:2])
                `LTCAP_IDX_CSR2: s = ltcap_pkg::LTCAP_SEL_CSR2;
                `LTCAP_IDX_RELOAD: s = ltcap_pkg::LTCAP_SEL_RELOAD;
                `LTCAP_IDX_CNT2: s = ltcap_pkg::LTCAP_SEL_CNT2;
                `LTCAP_IDX_CSR1: s = ltcap_pkg::LTCAP_SEL_CSR1;
                `LTCAP_IDX_CAP: s = ltcap_pkg::LTCAP_SEL_CAP;
                `LTCAP_IDX_EVT: s = ltcap_pkg::LTCAP_SEL_EVT;
                `LTCAP_IDX_MASK: s = ltcap_pkg::LTCAP_SEL_MASK;
                default: s = ltcap_pkg::LTCAP_SEL_NONE;
            endcase
        end
        return s;
    endfunction

    // Bus state
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    // Software control
    logic cap_ie_q, cap_ie_d;
    logic dbl_q, dbl_d;
    logic tb1_ie_q, tb1_ie_d;
    logic tb2_ie_q, tb2_ie_d;
    ltcap_pkg::ltcap_byte_type reload_q, reload_d;
    logic [`LTCAP_EVT_W-1:0] mask_q, mask_d;
    logic rd_csr1, rd_csr2, rd_cap, rd_evt;
    // Timer state
    ltcap_pkg::ltcap_byte_type cnt1_q, cnt1_d;
    ltcap_pkg::ltcap_byte_type cnt2_q, cnt2_d;
    ltcap_pkg::ltcap_byte_type cap_val_q, cap_val_d;
    logic phase_q, phase_d;
    logic tb1_f_q, tb1_f_d;
    logic tb2_f_q, tb2_f_d;
    logic cap_f_q, cap_f_d;
    logic [`LTCAP_EVT_W-1:0] evt_q, evt_d;
    logic run, tick, tick1, tick2, ovf1, ovf2, cap_evt, pin_edge;
    // Interrupt outputs
    logic irq_tb1_q, irq_tb1_d;
    logic irq_tb2_q, irq_tb2_d;
    logic irq_cap_q, irq_cap_d;
    logic irq_q, irq_d;
    ltcap_pkg::ltcap_byte_type rd_byte;

    assign run = !halt_mode;

    // Tick at oscillator/32 equivalent
    ltcap_prescaler #(
        .DIV(TICK_CYC)
    ) u_prescaler (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(run),
        .tick_q(tick)
    );

    // Pin passes two flops before the edge detector
    ltcap_pin_sync u_pin_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin(capture_input_pin),
        .edge_q(pin_edge)
    );

    // No wait state: data latched at end of setup, ready in the first access cycle
    always_comb begin
        pready_d = psel && !penable && !pready_q;
        pslverr_d = 1'b0;
        prdata_d = 32'h00000000;
        rd_byte = `LTCAP_RST_BYTE;
        if (pready_d) begin
            pslverr_d = (sel_of(paddr) == ltcap_pkg::LTCAP_SEL_NONE);
            case (sel_of(paddr))
                ltcap_pkg::LTCAP_SEL_CSR2: rd_byte = {6'h00, tb2_ie_q,
                                                      tb2_f_q};
                ltcap_pkg::LTCAP_SEL_RELOAD: rd_byte = reload_q;
                ltcap_pkg::LTCAP_SEL_CNT2: rd_byte = cnt2_q;
                ltcap_pkg::LTCAP_SEL_CSR1: rd_byte = {cap_ie_q, cap_f_q, dbl_q,
                                                      tb1_ie_q, tb1_f_q, 3'h0};
                ltcap_pkg::LTCAP_SEL_CAP: rd_byte = cap_val_q;
                ltcap_pkg::LTCAP_SEL_EVT: rd_byte = {5'h00, evt_q};
                ltcap_pkg::LTCAP_SEL_MASK: rd_byte = {5'h00, mask_q};
                default: rd_byte = `LTCAP_RST_BYTE;
            endcase
            if (!pwrite) begin
                prdata_d = {24'h000000, rd_byte};
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // Writes land at the completing edge; read side effects at the
    // latching edge, so an event in the access cycle is never lost
    always_comb begin
        cap_ie_d = cap_ie_q;
        dbl_d = dbl_q;
        tb1_ie_d = tb1_ie_q;
        tb2_ie_d = tb2_ie_q;
        reload_d = reload_q;
        mask_d = mask_q;
        rd_csr1 = 1'b0;
        rd_csr2 = 1'b0;
        rd_cap = 1'b0;
        rd_evt = 1'b0;
        if (psel && penable && pready_q && pwrite && pstrb[0]) begin
            case (sel_of(paddr))
                ltcap_pkg::LTCAP_SEL_CSR1: begin
                    cap_ie_d = pwdata[`LTCAP_CSR1_CAP_IE];
                    dbl_d = pwdata[`LTCAP_CSR1_DBL];
                    tb1_ie_d = pwdata[`LTCAP_CSR1_TB1_IE];
                end
                ltcap_pkg::LTCAP_SEL_CSR2: begin
                    tb2_ie_d = pwdata[`LTCAP_CSR2_TB2_IE];
                end
                ltcap_pkg::LTCAP_SEL_RELOAD: reload_d = pwdata[7:0];
                ltcap_pkg::LTCAP_SEL_MASK: mask_d = pwdata[`LTCAP_EVT_W-1:0];
                default: mask_d = mask_q;
            endcase
        end
        if (pready_d && !pwrite) begin
            rd_csr1 = (sel_of(paddr) == ltcap_pkg::LTCAP_SEL_CSR1);
            rd_csr2 = (sel_of(paddr) == ltcap_pkg::LTCAP_SEL_CSR2);
            rd_cap = (sel_of(paddr) == ltcap_pkg::LTCAP_SEL_CAP);
            rd_evt = (sel_of(paddr) == ltcap_pkg::LTCAP_SEL_EVT);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cap_ie_q <= 1'b0;
            dbl_q <= 1'b0;
            tb1_ie_q <= 1'b0;
            tb2_ie_q <= 1'b0;
            reload_q <= `LTCAP_RST_BYTE;
            mask_q <= `LTCAP_RST_EVT;
        end else begin
            cap_ie_q <= cap_ie_d;
            dbl_q <= dbl_d;
            tb1_ie_q <= tb1_ie_d;
            tb2_ie_q <= tb2_ie_d;
            reload_q <= reload_d;
            mask_q <= mask_d;
        end
    end

    // Counters, capture and flags; set always beats read-clear
    always_comb begin
        // counter 1 steps on every second tick when doubled
        phase_d = dbl_q ? (phase_q ^ (tick && run)) : 1'b0;
        tick1 = tick && run && (!dbl_q || phase_q);
        tick2 = tick && run;
        ovf1 = tick1 && (cnt1_q == `LTCAP_CNT1_TOP);
        cnt1_d = cnt1_q;
        if (tick1) begin
            cnt1_d = ovf1 ? 8'h00 : cnt1_q + 8'h01;
        end
        ovf2 = tick2 && (cnt2_q == `LTCAP_CNT2_TOP);
        cnt2_d = cnt2_q;
        if (tick2) begin
            cnt2_d = ovf2 ? reload_q : cnt2_q + 8'h01;
        end
        // capture only while flag is clear
        cap_evt = pin_edge && !cap_f_q;
        cap_val_d = cap_evt ? cnt1_q : cap_val_q;
        tb1_f_d = ovf1 || (tb1_f_q && !rd_csr1);
        tb2_f_d = ovf2 || (tb2_f_q && !rd_csr2);
        cap_f_d = cap_evt || (cap_f_q && !rd_cap);
        evt_d = evt_q & {`LTCAP_EVT_W{!rd_evt}};
        evt_d[`LTCAP_EVT_TB1] = evt_d[`LTCAP_EVT_TB1] || ovf1;
        evt_d[`LTCAP_EVT_TB2] = evt_d[`LTCAP_EVT_TB2] || ovf2;
        evt_d[`LTCAP_EVT_CAP] = evt_d[`LTCAP_EVT_CAP] || cap_evt;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt1_q <= 8'h00;
            cnt2_q <= `LTCAP_RST_BYTE;
            cap_val_q <= `LTCAP_RST_BYTE;
            phase_q <= 1'b0;
            tb1_f_q <= 1'b0;
            tb2_f_q <= 1'b0;
            cap_f_q <= 1'b0;
            evt_q <= `LTCAP_RST_EVT;
        end else begin
            cnt1_q <= cnt1_d;
            cnt2_q <= cnt2_d;
            cap_val_q <= cap_val_d;
            phase_q <= phase_d;
            tb1_f_q <= tb1_f_d;
            tb2_f_q <= tb2_f_d;
            cap_f_q <= cap_f_d;
            evt_q <= evt_d;
        end
    end

    // per-vector requests plus masked summary line
    always_comb begin
        irq_tb1_d = tb1_f_q && tb1_ie_q && !cpu_irq_mask;
        irq_tb2_d = tb2_f_q && tb2_ie_q && !cpu_irq_mask;
        irq_cap_d = cap_f_q && cap_ie_q && !cpu_irq_mask;
        irq_d = |(evt_q & mask_q);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_tb1_q <= 1'b0;
            irq_tb2_q <= 1'b0;
            irq_cap_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            irq_tb1_q <= irq_tb1_d;
            irq_tb2_q <= irq_tb2_d;
            irq_cap_q <= irq_cap_d;
            irq_q <= irq_d;
        end
    end

    assign irq_timebase1 = irq_tb1_q;
    assign irq_timebase2 = irq_tb2_q;
    assign irq_capture = irq_cap_q;
    assign irq = irq_q;

    // Checks on the timer behaviour
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    cnt1_range_a: assert property (cnt1_q <= `LTCAP_CNT1_TOP)
        else $error("counter 1 beyond its top");
    cnt1_wrap_a: assert property (
        tick1 && cnt1_q == `LTCAP_CNT1_TOP |=> cnt1_q == 8'h00 && tb1_f_q)
        else $error("counter 1 wrap or flag wrong");
    dbl_skip_a: assert property (
        dbl_q && tick && run && !phase_q |=> $stable(cnt1_q))
        else $error("doubled counter 1 stepped on skipped tick");
    cnt2_reload_a: assert property (
        tick2 && cnt2_q == `LTCAP_CNT2_TOP
        |=> cnt2_q == $past(reload_q) && tb2_f_q)
        else $error("counter 2 did not reload");
    cnt2_step_a: assert property (
        tick2 && cnt2_q != `LTCAP_CNT2_TOP |=> cnt2_q == $past(cnt2_q) + 8'h01)
        else $error("counter 2 jumped before overflow");
    tb1_clear_a: assert property (rd_csr1 && !ovf1 |=> !tb1_f_q)
        else $error("timebase 1 flag not cleared by read");
    tb2_clear_a: assert property (rd_csr2 && !ovf2 |=> !tb2_f_q)
        else $error("timebase 2 flag not cleared by read");
    cap_clear_a: assert property (rd_cap && !cap_evt |=> !cap_f_q)
        else $error("capture flag not cleared by read");
    cap_take_a: assert property (
        pin_edge && !cap_f_q |=> cap_f_q && cap_val_q == $past(cnt1_q))
        else $error("capture missed counter 1 value");
    cap_hold_a: assert property (cap_f_q |=> $stable(cap_val_q))
        else $error("capture register changed while flag set");
    halt_stop_a: assert property (
        halt_mode [*2] |-> $stable(cnt1_q) && $stable(cnt2_q))
        else $error("counters moved in halt");
    irq_tb1_a: assert property (
        tb1_f_q && tb1_ie_q && !cpu_irq_mask |=> irq_timebase1)
        else $error("timebase 1 request missing");
    irq_cap_a: assert property (
        cpu_irq_mask || !cap_ie_q |=> !irq_capture)
        else $error("capture request while masked or disabled");

    cnt1_ovf_c: cover property (ovf1 && dbl_q);
    cnt2_ovf_c: cover property (ovf2 && reload_q != 8'h00);
    cap_blocked_c: cover property (pin_edge && cap_f_q);
    irq_c: cover property (irq_timebase2 && irq);
endmodule
`default_nettype wire

// ### ltcap_defines.svh
// Register indices, field positions, reset values and timing counts
`ifndef LTCAP_DEFINES_SVH
`define LTCAP_DEFINES_SVH

// Register indices; the byte address is four times the index
`define LTCAP_IDX_CSR2 6'h08
`define LTCAP_IDX_RELOAD 6'h09
`define LTCAP_IDX_CNT2 6'h0A
`define LTCAP_IDX_CSR1 6'h0B
`define LTCAP_IDX_CAP 6'h0C
`define LTCAP_IDX_EVT 6'h0D
`define LTCAP_IDX_MASK 6'h0E

// Field positions in the first control and status register
`define LTCAP_CSR1_CAP_IE 7
`define LTCAP_CSR1_CAP_F 6
`define LTCAP_CSR1_DBL 5
`define LTCAP_CSR1_TB1_IE 4
`define LTCAP_CSR1_TB1_F 3

// Field positions in the second control and status register
`define LTCAP_CSR2_TB2_IE 1
`define LTCAP_CSR2_TB2_F 0

// Event status and mask layout
`define LTCAP_EVT_TB1 0
`define LTCAP_EVT_TB2 1
`define LTCAP_EVT_CAP 2
`define LTCAP_EVT_W 3

// Reset values
`define LTCAP_RST_BYTE 8'h00
`define LTCAP_RST_EVT 3'h0

// Counter limits
`define LTCAP_CNT1_TOP 8'hF9
`define LTCAP_CNT2_TOP 8'hFF

// Timing: one counter tick is the oscillator divided by 32
`define LTCAP_OSC_DIV 32
`define LTCAP_OSC_NS 125
`define LTCAP_CLK_NS 8
`define LTCAP_TICK_NS (`LTCAP_OSC_DIV * `LTCAP_OSC_NS)
`define LTCAP_TICK_CYC ((`LTCAP_TICK_NS + `LTCAP_CLK_NS - 1) / `LTCAP_CLK_NS)

`endif

// ### ltcap_pkg.sv
// Types shared by the lite timebase and capture timer
package ltcap_pkg;

    typedef logic [7:0] ltcap_byte_type;

    // Register selected by an APB address
    typedef enum logic [2:0] {
        LTCAP_SEL_CSR2 = 3'b000,
        LTCAP_SEL_RELOAD = 3'b001,
        LTCAP_SEL_CNT2 = 3'b010,
        LTCAP_SEL_CSR1 = 3'b011,
        LTCAP_SEL_CAP = 3'b100,
        LTCAP_SEL_EVT = 3'b101,
        LTCAP_SEL_MASK = 3'b110,
        LTCAP_SEL_NONE = 3'b111
    } ltcap_sel_type;

endpackage

// ### ltcap_prescaler.sv
// Tick generator dividing the system clock down to the counter rate
`timescale 1ns/1ps
`default_nettype none
module ltcap_prescaler #(
    parameter int DIV = 500
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Control and tick
    input wire logic run,
    output logic tick_q
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    if (DIV < 2) begin : g_div_chk
        $error("ltcap_prescaler: DIV must be at least 2");
    end

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic tick_d;

    // Frozen while halted so the phase resumes where it stopped
    always_comb begin
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (run) begin
            if (cnt_q == LAST) begin
                cnt_d = '0;
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + CW'(1);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end
endmodule
`default_nettype wire

// ### ltcap_pin_sync.sv
// Capture pin synchroniser with both-edge detector
`timescale 1ns/1ps
`default_nettype none
module ltcap_pin_sync (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Pin and edge pulse
    input wire logic pin,
    output logic edge_q
);
    logic meta_q;
    logic sync_q;
    logic last_q;
    logic [1:0] prime_q;
    logic [1:0] prime_d;
    logic edge_d;

    // Edges are ignored for two cycles, until sync_q holds a real pin sample; last_q still holds its reset value then
    always_comb begin
        prime_d = {prime_q[0], 1'b1};
        edge_d = prime_q[1] && (sync_q != last_q);
    end

    // Only the second stage reads the first
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
            prime_q <= 2'h0;
            edge_q <= 1'b0;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
            last_q <= sync_q;
            prime_q <= prime_d;
            edge_q <= edge_d;
        end
    end
endmodule
`default_nettype wire

// ### ltcap_top_tb.sv
// Self-checking testbench for the lite timebase and capture timer
`timescale 1ns/1ps
`default_nettype none
`include "ltcap_defines.svh"
module ltcap_top_tb;
    // Short prescale keeps the millisecond periods to 1000 and 2000 cycles
    localparam int tick = 4;
    localparam int tb1_per = (`LTCAP_CNT1_TOP + 1) * tick;
    localparam logic [7:0] a_csr2 = {`LTCAP_IDX_CSR2, 2'h0};
    localparam logic [7:0] a_rld = {`LTCAP_IDX_RELOAD, 2'h0};
    localparam logic [7:0] a_cnt2 = {`LTCAP_IDX_CNT2, 2'h0};
    localparam logic [7:0] a_csr1 = {`LTCAP_IDX_CSR1, 2'h0};
    localparam logic [7:0] a_cap = {`LTCAP_IDX_CAP, 2'h0};
    localparam logic [7:0] a_evt = {`LTCAP_IDX_EVT, 2'h0};
    localparam logic [7:0] a_mask = {`LTCAP_IDX_MASK, 2'h0};
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    logic [3:0] pstrb;
    logic halt_mode, cpu_irq_mask, capture_input_pin;
    logic irq_timebase1, irq_timebase2, irq_capture, irq;
    wire logic [3:0] irqs = {irq, irq_capture, irq_timebase2, irq_timebase1};
    int failures, checked, cyc, t0, t1, t2, t3;

    ltcap_top #(.ADDR_W(8), .TICK_CYC(tick)) ltcap_top_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .halt_mode(halt_mode), .cpu_irq_mask(cpu_irq_mask),
        .capture_input_pin(capture_input_pin),
        .irq_timebase1(irq_timebase1), .irq_timebase2(irq_timebase2),
        .irq_capture(irq_capture), .irq(irq)
    );

    // 125 MHz clock and a cycle count for measuring periods
    initial begin
        clk_sys = 1'h0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) cyc <= cyc + 1;

    task automatic check(input string name, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One APB transfer; the request stands until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [7:0] d);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk_sys);
        penable <= 1'h1;
        // No wait count assumed; only the watchdog ends a stuck transfer
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // Idle edge so back-to-back calls never drive psel twice at once
        @(posedge clk_sys);
    endtask

    // Bounded wait for one request line to reach a level
    task automatic wait_irq(input int i, input logic lvl, input int lim,
        output int t);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (irqs[i] !== lvl && n < lim);
        t = cyc;
        if (n >= lim) begin
            failures++;
            $display("wrong value irq wait expected %h seen %h", lvl, irqs[i]);
        end
    endtask

    // Clear a flag by reading, then time its next rise
    task automatic next_rise(input int i, input logic [7:0] a, input int lim,
        output int t);
        apb(1'h0, a, 8'h00);
        wait_irq(i, 1'h0, 8, t);
        wait_irq(i, 1'h1, lim, t);
    endtask

    task automatic t_reset();
        logic [7:0] regs [7];
        regs = '{a_cnt2, a_csr2, a_rld, a_csr1, a_cap, a_evt, a_mask};
        foreach (regs[k]) begin
            apb(1'h0, regs[k], 8'h00);
            check("reset value", rd, 32'h00000000);
        end
        apb(1'h0, 8'h3C, 8'h00);
        check("unmapped error", {31'h0, err}, 32'h1);
        apb(1'h1, a_cap, 8'h55);
        apb(1'h0, a_cap, 8'h00);
        check("capture read only", rd, 32'h0);
        // Low byte strobe off: the write must be dropped
        pstrb <= 4'hE;
        apb(1'h1, a_rld, 8'h77);
        pstrb <= 4'hF;
        apb(1'h0, a_rld, 8'h00);
        check("strobe gates write", rd, 32'h0);
        apb(1'h1, a_csr1, 8'hFF);
        apb(1'h0, a_csr1, 8'h00);
        check("csr1 writable bits", rd, 32'hB0);
    endtask

    task automatic t_tb1();
        apb(1'h1, a_csr1, 8'h10);
        wait_irq(0, 1'h1, 2 * tb1_per + 20, t0);
        check("summary masked", irq, 1'h0);
        cpu_irq_mask <= 1'h1;
        repeat (3) @(posedge clk_sys);
        check("cpu mask gates", irq_timebase1, 1'h0);
        cpu_irq_mask <= 1'h0;
        repeat (3) @(posedge clk_sys);
        check("request held", irq_timebase1, 1'h1);
        apb(1'h0, a_csr1, 8'h00);
        check("tb1 flag", rd[3], 1'h1);
        apb(1'h0, a_csr1, 8'h00);
        check("tb1 cleared", rd[3], 1'h0);
        next_rise(0, a_csr1, tb1_per + 20, t0);
        next_rise(0, a_csr1, tb1_per + 20, t1);
        check("tb1 period", t1 - t0, tb1_per);
        apb(1'h1, a_csr1, 8'h30);
        next_rise(0, a_csr1, 2 * tb1_per + 20, t0);
        next_rise(0, a_csr1, 2 * tb1_per + 20, t0);
        next_rise(0, a_csr1, 2 * tb1_per + 20, t1);
        check("doubled period", t1 - t0, 2 * tb1_per);
    endtask

    task automatic t_tb2();
        apb(1'h1, a_csr2, 8'h02);
        apb(1'h1, a_rld, 8'hF0);
        wait_irq(1, 1'h1, 1200, t0);
        apb(1'h0, a_csr2, 8'h00);
        check("tb2 flag", rd, 32'h3);
        next_rise(1, a_csr2, 1200, t0);
        next_rise(1, a_csr2, 300, t1);
        check("reload period", t1 - t0, (256 - 'hF0) * tick);
        apb(1'h0, a_cnt2, 8'h00);
        check("cnt2 from reload", rd >= 32'hF0, 1'h1);
        apb(1'h1, a_rld, 8'hC0);
        apb(1'h0, a_cnt2, 8'h00);
        check("reload deferred", rd >= 32'hF0, 1'h1);
        next_rise(1, a_csr2, 300, t2);
        check("old reload kept", t2 - t1, (256 - 'hF0) * tick);
        next_rise(1, a_csr2, 600, t3);
        check("new reload", t3 - t2, (256 - 'hC0) * tick);
    endtask

    task automatic t_cap();
        apb(1'h1, a_csr1, 8'h90);
        apb(1'h1, a_mask, 8'h04);
        apb(1'h0, a_cap, 8'h00);
        next_rise(0, a_csr1, tb1_per + 20, t0);
        repeat (400) @(posedge clk_sys);
        capture_input_pin <= ~capture_input_pin;
        // Second edge lands while the flag is set and must be dropped
        repeat (40) @(posedge clk_sys);
        capture_input_pin <= ~capture_input_pin;
        repeat (10) @(posedge clk_sys);
        check("capture irq", irq_capture, 1'h1);
        check("summary irq", irq, 1'h1);
        apb(1'h0, a_evt, 8'h00);
        check("capture event", rd[2], 1'h1);
        repeat (2) @(posedge clk_sys);
        check("summary cleared", irq, 1'h0);
        check("capture irq held", irq_capture, 1'h1);
        apb(1'h0, a_csr1, 8'h00);
        check("capture flag", rd[6], 1'h1);
        apb(1'h0, a_cap, 8'h00);
        check("capture value", rd >= 32'h63 && rd <= 32'h67, 1'h1);
        apb(1'h0, a_csr1, 8'h00);
        check("capture flag clear", rd[6], 1'h0);
        check("capture irq drop", irq_capture, 1'h0);
    endtask

    task automatic t_halt();
        halt_mode <= 1'h1;
        @(posedge clk_sys);
        apb(1'h0, a_cnt2, 8'h00);
        v = rd;
        repeat (50) @(posedge clk_sys);
        apb(1'h0, a_cnt2, 8'h00);
        check("halt freeze", rd, v);
        halt_mode <= 1'h0;
        repeat (50) @(posedge clk_sys);
        apb(1'h0, a_cnt2, 8'h00);
        check("run resumes", rd !== v, 1'h1);
    endtask

    // Main sequence: reset for six cycles, then each scenario
    initial begin
        rst_n = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        halt_mode = 1'h0;
        cpu_irq_mask = 1'h0;
        capture_input_pin = 1'h0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'h1;
        @(posedge clk_sys);
        t_reset();
        t_tb1();
        t_tb2();
        t_cap();
        t_halt();
        conclude();
    end

    // Watchdog well beyond the roughly 11000 cycles the scenarios need
    initial begin
        repeat (40000) @(posedge clk_sys);
        failures++;
        conclude();
    end
endmodule
`default_nettype wire
